/* omc_pkg.sv */
// operating mode controller: shared constants, command codes and mode encodings
// assumes a 25 MHz core clock and a separate external audio clock
package omc_pkg;

  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 40;
  // external clock declared lost after this long without a heartbeat edge
  localparam int CLK_LOSS_NS = 10000;
  localparam int CLK_LOSS_CYC = (CLK_LOSS_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  // stand-by wait before falling back to sleep
  localparam int STBY_TIMEOUT_US = 1000;
  localparam int STBY_TIMEOUT_CYC = (STBY_TIMEOUT_US * 1000) / SYS_CLK_PERIOD_NS;
  localparam int LOSS_CNT_W = 9;
  localparam int STBY_CNT_W = 24;
  // heartbeat counter width: the heartbeat toggles once per 2^HB_DIV_W = 8 audio clock cycles
  localparam int HB_DIV_W = 3;

  // ----------------------------------------------------------------
  // data widths
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 16;
  localparam int PRESET_W = 3;
  localparam int CMD_W = 2;

  // ----------------------------------------------------------------
  // boot strap presets
  // ----------------------------------------------------------------
  localparam logic [PRESET_W-1:0] PRESET_EXT_LAST = 3'h2;
  localparam logic [PRESET_W-1:0] PRESET_ACT_LAST = 3'h5;
  localparam logic [PRESET_W-1:0] PRESET_TONE = 3'h6;
  localparam logic [PRESET_W-1:0] PRESET_PASS = 3'h7;

  // ----------------------------------------------------------------
  // mode-change commands from the host
  // ----------------------------------------------------------------
  localparam logic [CMD_W-1:0] CMD_NONE = 2'h0;
  localparam logic [CMD_W-1:0] CMD_ACTIVE = 2'h1;
  localparam logic [CMD_W-1:0] CMD_BYPASS = 2'h2;
  localparam logic [CMD_W-1:0] CMD_SLEEP = 2'h3;

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OMC_BOOT = 3'h0,
    OMC_ACTIVE = 3'h1,
    OMC_BYPASS = 3'h2,
    OMC_SLEEP = 3'h3,
    OMC_STANDBY = 3'h4,
    OMC_EXTBOOT = 3'h5
  } omc_mode_t;

endpackage

/* omc_link_if.sv */
// control and statistics carrier between the core-clock controller and the audio-clock path
// each signal is driven in one domain only; the receiving side synchronises all but the handshake-held peak words
`timescale 1ns/1ns
interface omc_link_if;
  import omc_pkg::*;

  // core domain -> audio domain, levels and a request toggle
  logic proc_en;
  logic byp_en;
  logic stat_en;
  logic stat_req;
  // audio domain -> core domain, toggles and handshake-held words
  logic stat_ack;
  logic heartbeat;
  logic [SAMPLE_W-1:0] peak0;
  logic [SAMPLE_W-1:0] peak1;

  modport core (output proc_en, output byp_en, output stat_en, output stat_req,
                input stat_ack, input heartbeat, input peak0, input peak1);
  modport audio (input proc_en, input byp_en, input stat_en, input stat_req,
                 output stat_ack, output heartbeat, output peak0, output peak1);
endinterface

/* omc_audio_path.sv */
// audio-clock side: output routing, input peak statistics and the clock heartbeat
// assumes ext_clk_i may stop at any time; reset is released synchronously here
`timescale 1ns/1ns
module omc_audio_path (
  input wire logic ext_clk_i,
  input wire logic rstn_i,
  input wire logic [omc_pkg::SAMPLE_W-1:0] mic0_i,
  input wire logic [omc_pkg::SAMPLE_W-1:0] mic1_i,
  input wire logic [omc_pkg::SAMPLE_W-1:0] nr0_i,
  input wire logic [omc_pkg::SAMPLE_W-1:0] nr1_i,
  output logic [omc_pkg::SAMPLE_W-1:0] aud0_o,
  output logic [omc_pkg::SAMPLE_W-1:0] aud1_o,
  omc_link_if.audio link
);
  import omc_pkg::*;

  // ----------------------------------------------------------------
  // reset release synchroniser
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_ok;
  always_ff @(posedge ext_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_ok <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_ok <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // state and next values
  // ----------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic req_seen;
  logic ack;
  logic hb;
  logic [HB_DIV_W-1:0] hb_cnt;
  logic [SAMPLE_W-1:0] pk0, pk1, hold0, hold1, out0, out1;
  logic next_req_seen, next_ack, next_hb;
  logic [HB_DIV_W-1:0] next_hb_cnt;
  logic [SAMPLE_W-1:0] next_pk0, next_pk1, next_hold0, next_hold1, next_out0, next_out1;

  // magnitude of a signed sample, full negative reads as 16'h8000
  function automatic logic [SAMPLE_W-1:0] mag(input logic [SAMPLE_W-1:0] s);
    mag = s[SAMPLE_W-1] ? (~s + 16'h0001) : s;
  endfunction

  // synchronised controls: proc, byp, stat_en, stat_req
  wire proc_s = sync2[0];
  wire byp_s = sync2[1];
  wire stat_s = sync2[2];
  wire req_s = sync2[3];

  // ----------------------------------------------------------------
  // next-value logic
  // ----------------------------------------------------------------
  always_comb begin
    next_hb_cnt = hb_cnt + 3'h1;
    next_hb = (hb_cnt == '1) ? ~hb : hb;
    // bypass copies inputs untouched; active forwards the engine result
    if (byp_s) begin
      next_out0 = mic0_i;
      next_out1 = mic1_i;
    end else if (proc_s) begin
      next_out0 = nr0_i;
      next_out1 = nr1_i;
    end else begin
      next_out0 = 16'h0000;
      next_out1 = 16'h0000;
    end
    // peak tracking only while a processing mode is running
    next_pk0 = pk0;
    next_pk1 = pk1;
    if (stat_s && (mag(mic0_i) > pk0)) begin
      next_pk0 = mag(mic0_i);
    end
    if (stat_s && (mag(mic1_i) > pk1)) begin
      next_pk1 = mag(mic1_i);
    end
    // snapshot on a new request; held words stay put until the next one
    next_req_seen = req_s;
    next_ack = ack;
    next_hold0 = hold0;
    next_hold1 = hold1;
    if (req_s != req_seen) begin
      next_hold0 = next_pk0;
      next_hold1 = next_pk1;
      next_pk0 = 16'h0000;
      next_pk1 = 16'h0000;
      next_ack = ~ack;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ext_clk_i or negedge rst_ok) begin
    if (!rst_ok) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      req_seen <= 1'b0;
      ack <= 1'b0;
      hb <= 1'b0;
      hb_cnt <= 3'h0;
      pk0 <= 16'h0000;
      pk1 <= 16'h0000;
      hold0 <= 16'h0000;
      hold1 <= 16'h0000;
      out0 <= 16'h0000;
      out1 <= 16'h0000;
    end else begin
      sync1 <= {link.stat_req, link.stat_en, link.byp_en, link.proc_en};
      sync2 <= sync1;
      req_seen <= next_req_seen;
      ack <= next_ack;
      hb <= next_hb;
      hb_cnt <= next_hb_cnt;
      pk0 <= next_pk0;
      pk1 <= next_pk1;
      hold0 <= next_hold0;
      hold1 <= next_hold1;
      out0 <= next_out0;
      out1 <= next_out1;
    end
  end

  assign aud0_o = out0;
  assign aud1_o = out1;
  assign link.stat_ack = ack;
  assign link.heartbeat = hb;
  assign link.peak0 = hold0;
  assign link.peak1 = hold1;
endmodule

/* omc_top.sv */
// operating mode controller: boot selection, host commands, sleep, wake and stand-by
// assumes host commands arrive decoded on the core clock; scl and strap are raw pins
// Summary of operation
// - strap preset 3 to 5 boots into active; clock return from sleep resumes active
// - host active command switches to active from any awake mode
// - active mode runs noise reduction and forwards processed samples
// - active mode gathers input peak statistics readable by the host
// - strap presets 6 and 7 boot into bypass; host bypass command enters it
// - bypass copies each input sample unchanged to the outputs
// - bypass mode gathers input peak statistics readable by the host too
// - host sleep command puts the device to sleep
// - after commanded sleep only activity on the host clock line wakes it
// - loss of the external clock forces sleep automatically
// - sleep stops processing, disables analog and selects the slow oscillator
// - a wake by host clock activity lands in stand-by, not a processing mode
// - stand-by waits for a host mode command and then enters that mode
// - without a command stand-by falls back to sleep awaiting a new wake
// - strap preset 7 starts in full passthrough bypass
`timescale 1ns/1ns
module omc_top #(
  parameter int STBY_CYC = omc_pkg::STBY_TIMEOUT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ext_clk_i,
  input wire logic [omc_pkg::PRESET_W-1:0] boot_sel_i,
  input wire logic scl_i,
  input wire logic cmd_valid_i,
  input wire logic [omc_pkg::CMD_W-1:0] cmd_code_i,
  input wire logic stat_rd_i,
  output logic stat_valid_o,
  output logic stat_busy_o,
  output logic [omc_pkg::SAMPLE_W-1:0] stat_peak0_o,
  output logic [omc_pkg::SAMPLE_W-1:0] stat_peak1_o,
  input wire logic [omc_pkg::SAMPLE_W-1:0] mic0_i,
  input wire logic [omc_pkg::SAMPLE_W-1:0] mic1_i,
  input wire logic [omc_pkg::SAMPLE_W-1:0] nr0_i,
  input wire logic [omc_pkg::SAMPLE_W-1:0] nr1_i,
  output logic [omc_pkg::SAMPLE_W-1:0] aud0_o,
  output logic [omc_pkg::SAMPLE_W-1:0] aud1_o,
  output logic [2:0] mode_o,
  output logic nr_run_o,
  output logic analog_en_o,
  output logic slow_osc_sel_o,
  output logic tone_diag_o,
  output logic ext_boot_o,
  output logic clk_lost_o
);
  import omc_pkg::*;

  omc_link_if link ();

  // ----------------------------------------------------------------
  // audio-clock path
  // ----------------------------------------------------------------
  omc_audio_path u_audio (
    .ext_clk_i(ext_clk_i),
    .rstn_i(rstn_i),
    .mic0_i(mic0_i),
    .mic1_i(mic1_i),
    .nr0_i(nr0_i),
    .nr1_i(nr1_i),
    .aud0_o(aud0_o),
    .aud1_o(aud1_o),
    .link(link)
  );

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // pins and audio-domain toggles each pass two flops before use
  logic [PRESET_W-1:0] strap_m, strap_s;
  logic [2:0] in_m, in_s;
  logic scl_d, hb_d, ack_d;
  // strap flops carry no reset so the preset has settled by the time reset lifts
  always_ff @(posedge sys_clk_i) begin
    strap_m <= boot_sel_i;
    strap_s <= strap_m;
  end

  // scl idles high on its pull-up; resetting its flops high avoids a false wake edge
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_m <= 3'h1;
      in_s <= 3'h1;
      scl_d <= 1'b1;
      hb_d <= 1'b0;
      ack_d <= 1'b0;
    end else begin
      in_m <= {link.stat_ack, link.heartbeat, scl_i};
      in_s <= in_m;
      scl_d <= in_s[0];
      hb_d <= in_s[1];
      ack_d <= in_s[2];
    end
  end

  wire scl_edge = in_s[0] ^ scl_d;
  wire hb_edge = in_s[1] ^ hb_d;
  wire ack_edge = in_s[2] ^ ack_d;

  // decoded host command, one cycle wide
  function automatic logic is_cmd(input logic v, input logic [CMD_W-1:0] c,
                                  input logic [CMD_W-1:0] want);
    is_cmd = v && (c == want);
  endfunction

  wire cmd_act = is_cmd(cmd_valid_i, cmd_code_i, CMD_ACTIVE);
  wire cmd_byp = is_cmd(cmd_valid_i, cmd_code_i, CMD_BYPASS);
  wire cmd_slp = is_cmd(cmd_valid_i, cmd_code_i, CMD_SLEEP);

  // ----------------------------------------------------------------
  // external clock monitor
  // ----------------------------------------------------------------
  // the heartbeat toggles every few audio cycles; silence for the loss
  // window means the clock stopped. the window is far longer than the
  // heartbeat period so a slow but running clock is not flagged.
  logic [LOSS_CNT_W-1:0] loss_cnt, next_loss_cnt;
  logic lost, next_lost;
  always_comb begin
    next_loss_cnt = loss_cnt;
    next_lost = lost;
    if (hb_edge) begin
      next_loss_cnt = '0;
      next_lost = 1'b0;
    end else if (loss_cnt == LOSS_CNT_W'(CLK_LOSS_CYC - 1)) begin
      next_lost = 1'b1;
    end else begin
      next_loss_cnt = loss_cnt + 9'h001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      loss_cnt <= '0;
      lost <= 1'b0;
    end else begin
      loss_cnt <= next_loss_cnt;
      lost <= next_lost;
    end
  end

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  omc_mode_t mode, next_mode;
  logic boot_wait, next_boot_wait;
  logic tone, next_tone;
  logic host_sleep, next_host_sleep;
  logic [STBY_CNT_W-1:0] stby_cnt, next_stby_cnt;

  always_comb begin
    next_mode = mode;
    next_boot_wait = 1'b0;
    next_tone = tone;
    next_host_sleep = host_sleep;
    next_stby_cnt = stby_cnt;
    case (mode)
      OMC_BOOT: begin
        // one spare cycle lets the strap synchroniser settle
        if (boot_wait) begin
          next_boot_wait = 1'b0;
          if (strap_s <= PRESET_EXT_LAST) begin
            next_mode = OMC_EXTBOOT;
          end else if (strap_s <= PRESET_ACT_LAST) begin
            next_mode = OMC_ACTIVE;
          end else begin
            next_mode = OMC_BYPASS;
            next_tone = (strap_s == PRESET_TONE);           // tone diagnostic preset only
          end
        end else begin
          next_boot_wait = 1'b1;
        end
      end
      OMC_ACTIVE, OMC_BYPASS, OMC_STANDBY, OMC_EXTBOOT: begin
        if (mode == OMC_STANDBY) begin
          next_stby_cnt = stby_cnt + 24'h000001;
        end
        // clock loss wins over any command in the same cycle
        if (lost) begin
          next_mode = OMC_SLEEP;
          next_host_sleep = 1'b0;
        end else if (cmd_slp) begin
          next_mode = OMC_SLEEP;
          next_host_sleep = 1'b1;
        end else if (cmd_act) begin
          next_mode = OMC_ACTIVE;
          next_tone = 1'b0;
        end else if (cmd_byp) begin
          next_mode = OMC_BYPASS;
          next_tone = 1'b0;
        end else if ((mode == OMC_STANDBY) && (stby_cnt == STBY_CNT_W'(STBY_CYC - 1))) begin
          next_mode = OMC_SLEEP;
          next_host_sleep = 1'b1;
        end
      end
      OMC_SLEEP: begin
        next_stby_cnt = '0;
        if (host_sleep) begin
          // commanded sleep ignores commands and the clock; only scl wakes
          if (scl_edge) begin
            next_mode = OMC_STANDBY;
          end
        end else if (scl_edge) begin
          next_mode = OMC_STANDBY;
          next_host_sleep = 1'b1;
        end else if (!lost) begin
          next_mode = OMC_ACTIVE;
          next_tone = 1'b0;
        end
      end
      default: begin
        next_mode = OMC_BOOT;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode <= OMC_BOOT;
      boot_wait <= 1'b0;
      tone <= 1'b0;
      host_sleep <= 1'b0;
      stby_cnt <= '0;
    end else begin
      mode <= next_mode;
      boot_wait <= next_boot_wait;
      tone <= next_tone;
      host_sleep <= next_host_sleep;
      stby_cnt <= next_stby_cnt;
    end
  end

  // ----------------------------------------------------------------
  // mode outputs
  // ----------------------------------------------------------------
  // all registered so the audio domain sees glitch-free levels
  logic proc, byp, stat, analog, slow_osc;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      proc <= 1'b0;
      byp <= 1'b0;
      stat <= 1'b0;
      analog <= 1'b0;
      slow_osc <= 1'b0;
    end else begin
      proc <= (next_mode == OMC_ACTIVE);
      byp <= (next_mode == OMC_BYPASS);
      stat <= (next_mode == OMC_ACTIVE) || (next_mode == OMC_BYPASS);
      analog <= (next_mode != OMC_SLEEP);
      slow_osc <= (next_mode == OMC_SLEEP);
    end
  end

  assign link.proc_en = proc;
  assign link.byp_en = byp;
  assign link.stat_en = stat;
  assign mode_o = mode;
  assign nr_run_o = proc;
  assign analog_en_o = analog;
  assign slow_osc_sel_o = slow_osc;
  assign tone_diag_o = tone && byp;
  assign ext_boot_o = (mode == OMC_EXTBOOT);
  assign clk_lost_o = lost;

  // ----------------------------------------------------------------
  // statistics read handshake
  // ----------------------------------------------------------------
  // request toggles across; peak words are held by the audio side
  // from its ack toggle until the next request, so sampling them
  // after the synchronised ack edge is safe. a stopped audio clock
  // leaves a request pending until the clock returns.
  logic req, next_req;
  logic sval, next_sval;
  logic [SAMPLE_W-1:0] sp0, sp1, next_sp0, next_sp1;
  wire busy = req ^ ack_d;
  always_comb begin
    next_req = req;
    next_sval = 1'b0;
    next_sp0 = sp0;
    next_sp1 = sp1;
    if (stat_rd_i && !busy) begin
      next_req = ~req;
    end
    if (ack_edge) begin
      next_sval = 1'b1;
      next_sp0 = link.peak0;
      next_sp1 = link.peak1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req <= 1'b0;
      sval <= 1'b0;
      sp0 <= 16'h0000;
      sp1 <= 16'h0000;
    end else begin
      req <= next_req;
      sval <= next_sval;
      sp0 <= next_sp0;
      sp1 <= next_sp1;
    end
  end

  assign link.stat_req = req;
  assign stat_valid_o = sval;
  assign stat_busy_o = busy;
  assign stat_peak0_o = sp0;
  assign stat_peak1_o = sp1;
endmodule

/* omc_props.sv */
// checker: mode sequencing properties of the operating mode controller
// assumes it is bound to omc_top and sees only the top module's ports
`timescale 1ns/1ns
module omc_props #(
  parameter int STBY_CYC = 50
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [omc_pkg::PRESET_W-1:0] boot_sel_i,
  input wire logic scl_i,
  input wire logic cmd_valid_i,
  input wire logic [omc_pkg::CMD_W-1:0] cmd_code_i,
  input wire logic [2:0] mode_o,
  input wire logic nr_run_o,
  input wire logic analog_en_o,
  input wire logic slow_osc_sel_o,
  input wire logic tone_diag_o,
  input wire logic clk_lost_o
);
  import omc_pkg::*;
  logic scl_q;
  logic next_scl_q;
  logic [7:0] scl_age;
  logic [7:0] next_scl_age;
  logic [31:0] stby_cnt;
  logic [31:0] next_stby_cnt;
  // scl edge age saturates so a stale edge never looks recent again
  always_comb begin
    next_scl_q = scl_i;
    next_scl_age = (scl_i != scl_q) ? 8'h00 : ((scl_age == 8'hFF) ? scl_age : scl_age + 8'h01);
    next_stby_cnt = (mode_o == OMC_STANDBY) ? stby_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q <= 1'b1;
      scl_age <= 8'hFF;
      stby_cnt <= 32'h0;
    end else begin
      scl_q <= next_scl_q;
      scl_age <= next_scl_age;
      stby_cnt <= next_stby_cnt;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_boot_mode: assert property (
    $past(mode_o) == OMC_BOOT && mode_o != OMC_BOOT |-> tone_diag_o == (boot_sel_i == PRESET_TONE) &&
    mode_o == ((boot_sel_i <= PRESET_EXT_LAST) ? OMC_EXTBOOT : (boot_sel_i <= PRESET_ACT_LAST) ? OMC_ACTIVE : OMC_BYPASS))
    else $error("boot mode does not follow the strap preset");
  a_cmd_active: assert property (
    cmd_valid_i && cmd_code_i == CMD_ACTIVE && mode_o inside {OMC_BYPASS, OMC_STANDBY, OMC_EXTBOOT}
    |=> mode_o == OMC_ACTIVE || $past(clk_lost_o)) else $error("active command not taken");
  a_cmd_bypass: assert property (
    cmd_valid_i && cmd_code_i == CMD_BYPASS && mode_o inside {OMC_ACTIVE, OMC_STANDBY, OMC_EXTBOOT}
    |=> mode_o == OMC_BYPASS || $past(clk_lost_o)) else $error("bypass command not taken");
  a_cmd_sleep: assert property (
    cmd_valid_i && cmd_code_i == CMD_SLEEP && mode_o inside {OMC_ACTIVE, OMC_BYPASS, OMC_STANDBY}
    |=> mode_o == OMC_SLEEP) else $error("sleep command not taken");
  a_sleep_outs: assert property (
    mode_o == OMC_SLEEP |-> slow_osc_sel_o && !analog_en_o && !nr_run_o) else $error("sleep outputs wrong");
  a_active_outs: assert property (
    mode_o == OMC_ACTIVE |-> nr_run_o && analog_en_o && !slow_osc_sel_o) else $error("active outputs wrong");
  a_wake_target: assert property (
    $past(mode_o) == OMC_SLEEP && mode_o != OMC_SLEEP |-> mode_o inside {OMC_STANDBY, OMC_ACTIVE})
    else $error("sleep left to a wrong mode");
  a_wake_scl: assert property (
    $past(mode_o) == OMC_SLEEP && mode_o == OMC_STANDBY |-> scl_age <= 8'h06) else $error("wake without scl edge");
  a_stby_max: assert property (
    mode_o == OMC_STANDBY |-> stby_cnt < STBY_CYC + 2) else $error("stand-by outlasts its timeout");
  a_stby_min: assert property (
    $past(mode_o) == OMC_STANDBY && mode_o == OMC_SLEEP && !$past(cmd_valid_i) && !clk_lost_o
    |-> stby_cnt + 2 >= STBY_CYC) else $error("stand-by left too early");
  a_loss_sleep: assert property (
    $rose(clk_lost_o) |-> ##[0:2] mode_o == OMC_SLEEP) else $error("clock loss did not force sleep");
endmodule
bind omc_top omc_props #(.STBY_CYC(STBY_CYC)) props_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .boot_sel_i(boot_sel_i), .scl_i(scl_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
  .mode_o(mode_o), .nr_run_o(nr_run_o), .analog_en_o(analog_en_o), .slow_osc_sel_o(slow_osc_sel_o),
  .tone_diag_o(tone_diag_o), .clk_lost_o(clk_lost_o));

/* omc_host_bfm.sv */
// partner: host controller issuing decoded mode commands and waking the device on scl
// assumes the device samples these on the rising core clock edge
`timescale 1ns/1ns
module omc_host_bfm (
  input wire logic sys_clk_i,
  output logic cmd_valid_o,
  output logic [omc_pkg::CMD_W-1:0] cmd_code_o,
  output logic scl_o
);
  import omc_pkg::*;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = CMD_NONE;
    scl_o = 1'b1;
  end
  // one command per core cycle; the code is inverted after so stale data is never mistaken
  task automatic send_cmd(input logic [CMD_W-1:0] code);
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o = code;
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b0;
    cmd_code_o = ~code;
  endtask
  // scl pulled low one cycle, then back to its pulled-up idle level
  task automatic wake();
    repeat (2) begin
      @(negedge sys_clk_i);
      scl_o = ~scl_o;
    end
  endtask
endmodule

/* test_operating_mode_controller.sv */
// testbench: boot presets, host commands, statistics, sleep, wake, stand-by timeout, clock loss
// assumes the host model and the property checker are compiled before it
`timescale 1ns/1ns
module test_operating_mode_controller;
  import omc_pkg::*;
  localparam int STBY = 50;
  logic sys_clk, ext_clk, ext_run, rstn, cmd_valid, scl, stat_rd, stat_valid, stat_busy;
  logic nr_run, analog_en, slow_osc, tone, ext_boot, clk_lost;
  logic [PRESET_W-1:0] boot_sel;
  logic [CMD_W-1:0] cmd_code;
  logic [SAMPLE_W-1:0] mic0, mic1, nr0, nr1, aud0, aud1, peak0, peak1;
  logic [2:0] mode;
  int error_cnt = 0;
  int num_checks = 0;
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // audio clock parks low while stopped, as a removed external clock would
  initial begin
    ext_clk = 1'b0;
    #7;
    forever #6 ext_clk = ext_run ? ~ext_clk : 1'b0;
  end
  omc_host_bfm host_u (.sys_clk_i(sys_clk), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .scl_o(scl));
  omc_top #(.STBY_CYC(STBY)) dut_u (.sys_clk_i(sys_clk), .rstn_i(rstn), .ext_clk_i(ext_clk),
    .boot_sel_i(boot_sel), .scl_i(scl), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .stat_rd_i(stat_rd),
    .stat_valid_o(stat_valid), .stat_busy_o(stat_busy), .stat_peak0_o(peak0), .stat_peak1_o(peak1),
    .mic0_i(mic0), .mic1_i(mic1), .nr0_i(nr0), .nr1_i(nr1), .aud0_o(aud0), .aud1_o(aud1), .mode_o(mode),
    .nr_run_o(nr_run), .analog_en_o(analog_en), .slow_osc_sel_o(slow_osc), .tone_diag_o(tone),
    .ext_boot_o(ext_boot), .clk_lost_o(clk_lost));
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_mode(input logic [2:0] exp);
    chk_val({13'h0, mode}, {13'h0, exp});
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0, got}, {15'h0, exp});
  endtask
  // bounded poll; the mode is then compared by the caller
  task automatic wait_mode(input logic [2:0] m, input int n);
    for (int i = 0; i < n && mode !== m; i++) @(negedge sys_clk);
  endtask
  task automatic do_reset(input logic [PRESET_W-1:0] p);
    @(negedge sys_clk);
    rstn = 1'b0;
    boot_sel = p;
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic snap();
    int i;
    i = 0;
    @(negedge sys_clk);
    stat_rd = 1'b1;
    @(negedge sys_clk);
    stat_rd = 1'b0;
    chk_bit(stat_busy, 1'b1);
    while (stat_valid !== 1'b1 && i < 60) begin
      @(negedge sys_clk);
      i++;
    end
    chk_bit(stat_valid, 1'b1);
    chk_bit(stat_busy, 1'b0);
  endtask
  task automatic t_boot();
    for (int p = 0; p < 8; p++) begin
      do_reset(p[PRESET_W-1:0]);
      chk_mode(p <= 2 ? OMC_EXTBOOT : p <= 5 ? OMC_ACTIVE : OMC_BYPASS);
      chk_bit(tone, p == 6);
      chk_bit(ext_boot, p <= 2);
    end
    $display("test boot done");
  endtask
  task automatic t_route();
    do_reset(PRESET_PASS);
    mic0 = 16'h1234;
    mic1 = 16'hFEDC;
    repeat (4) @(negedge sys_clk);
    chk_val(aud0, mic0);
    chk_val(aud1, mic1);
    host_u.send_cmd(CMD_ACTIVE);
    chk_mode(OMC_ACTIVE);
    chk_bit(nr_run, 1'b1);
    repeat (4) @(negedge sys_clk);
    chk_val(aud0, nr0);
    chk_val(aud1, nr1);
    $display("test routing done");
  endtask
  task automatic t_stats();
    host_u.send_cmd(CMD_BYPASS);
    chk_mode(OMC_BYPASS);
    mic0 = 16'h0000;
    mic1 = 16'h0000;
    repeat (4) @(negedge sys_clk);
    snap();
    host_u.send_cmd(CMD_ACTIVE);
    mic0 = 16'hFFFB;
    mic1 = 16'h0123;
    repeat (4) @(negedge sys_clk);
    snap();
    chk_val(peak0, 16'h0005);
    chk_val(peak1, 16'h0123);
    host_u.send_cmd(CMD_BYPASS);
    mic0 = 16'h8000;
    mic1 = 16'h7FFF;
    repeat (4) @(negedge sys_clk);
    snap();
    chk_val(peak0, 16'h8000);
    chk_val(peak1, 16'h7FFF);
    $display("test statistics done");
  endtask
  task automatic t_sleep();
    host_u.send_cmd(CMD_SLEEP);
    chk_mode(OMC_SLEEP);
    chk_bit(slow_osc, 1'b1);
    chk_bit(analog_en, 1'b0);
    host_u.send_cmd(CMD_ACTIVE);
    repeat (20) @(negedge sys_clk);
    chk_mode(OMC_SLEEP);
    host_u.wake();
    wait_mode(OMC_STANDBY, 10);
    chk_mode(OMC_STANDBY);
    host_u.send_cmd(CMD_BYPASS);
    chk_mode(OMC_BYPASS);
    $display("test sleep done");
  endtask
  task automatic t_stby();
    host_u.send_cmd(CMD_SLEEP);
    host_u.wake();
    wait_mode(OMC_STANDBY, 10);
    repeat (STBY - 5) @(negedge sys_clk);
    chk_mode(OMC_STANDBY);
    wait_mode(OMC_SLEEP, 10);
    chk_mode(OMC_SLEEP);
    host_u.wake();
    wait_mode(OMC_STANDBY, 10);
    host_u.send_cmd(CMD_ACTIVE);
    chk_mode(OMC_ACTIVE);
    $display("test stand-by done");
  endtask
  task automatic t_loss();
    ext_run = 1'b0;
    wait_mode(OMC_SLEEP, 300);
    chk_mode(OMC_SLEEP);
    chk_bit(clk_lost, 1'b1);
    ext_run = 1'b1;
    wait_mode(OMC_ACTIVE, 100);
    chk_mode(OMC_ACTIVE);
    $display("test clock loss done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the whole run needs about 550 core cycles
  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    rstn = 1'b0;
    ext_run = 1'b1;
    boot_sel = PRESET_PASS;
    stat_rd = 1'b0;
    mic0 = 16'h0000;
    mic1 = 16'h0000;
    nr0 = 16'h0A5A;
    nr1 = 16'h5AA5;
    t_boot();
    t_route();
    t_stats();
    t_sleep();
    t_stby();
    t_loss();
    print_verdict();
  end
endmodule
